// ==== nfh_pkg.sv ====
`default_nettype none
package nfh_pkg;

	// ==========================================================
	// Timing, in nanoseconds, and derived clock counts
	// ==========================================================
	localparam int CLK_PERIOD_NS = 8;        // Core clock period
	localparam int T_WP_NS       = 15;       // Write strobe low time
	localparam int T_WH_NS       = 10;       // Strobe high time
	localparam int T_RD_LOW_NS   = 40;       // Read strobe low, covers sync
	localparam int T_WHR_NS      = 80;       // Write_to_read_delay
	// Least times round up to whole cycles
	localparam int WP_CYC  = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WH_CYC  = (T_WH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RDL_CYC =
		(T_RD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WHR_CYC = (T_WHR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// Command bytes on the flash bus
	// ==========================================================
	localparam logic [7:0] CMD_STATUS     = 8'h70; // Plain status
	localparam logic [7:0] CMD_STATUS_ENH = 8'h78; // Enhanced status
	localparam logic [7:0] CMD_READ_MODE  = 8'h00; // Back to data output
	localparam logic [7:0] CMD_RAND_READ  = 8'h05; // Random read, first
	localparam logic [7:0] CMD_RAND_CONF  = 8'he0; // Random read, confirm

	// ==========================================================
	// die_status bit layout
	// ==========================================================
	localparam int SB_WP   = 7;              // 1 = not protected
	localparam int SB_RDY  = 6;              // die_ready_flag
	localparam int SB_ARRAY_READY_FLAG = 5;              // array_ready_flag
	localparam int SB_DC   = 2;              // Meaningless bit
	localparam logic [7:0] STATUS_MASK = 8'hfb; // Drops the meaningless bit

	// ==========================================================
	// Controller register map
	// ==========================================================
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_CTRL = 8'h00; // Op, poll, wp, multi, otp
	localparam logic [7:0] OFF_ROW  = 8'h04; // 24-bit row address
	localparam logic [7:0] OFF_COL  = 8'h08; // 16-bit column address
	localparam logic [7:0] OFF_STAT = 8'h0c; // Engine state and die_status
	localparam logic [7:0] OFF_DATA = 8'h10; // Last data byte read
	localparam int CF_OP_LSB = 0;            // Op field, 3 bits
	localparam int CF_OP_MSB = 2;
	localparam int CF_POLL   = 3;            // Re-read status until ready
	localparam int CF_WP_OFF = 4;            // Drives write-protect pin high
	localparam int CF_MULTI  = 5;            // Target holds several dies
	localparam int CF_OTP    = 6;            // Device is in OTP mode
	localparam int ST_BUSY_B = 0;            // STAT: sequence running
	localparam int ST_REF_B  = 1;            // STAT: last order refused
	localparam int ST_RB_B   = 2;            // STAT: ready/busy pin level
	localparam int ST_SMODE  = 3;            // STAT: device in status output
	localparam int ST_DSEL   = 4;            // STAT: die picked by 78h
	localparam int ST_DS_LSB = 8;            // STAT: die_status byte

	// ==========================================================
	// Types
	// ==========================================================
	typedef enum logic [2:0] {
		OP_NOP, OP_STATUS, OP_STATUS_ENH, OP_READ_MODE,
		OP_RAND_READ, OP_DATA_READ
	} nfh_op_t;

	typedef enum logic [1:0] {BK_CMD, BK_ADDR, BK_READ} nfh_bkind_t;

	typedef enum logic [2:0] {
		IT_CMD, IT_ADDR, IT_GAP, IT_READ, IT_END
	} nfh_item_t;

	typedef struct packed {
		nfh_item_t  kind;                    // What this step does
		logic [7:0] val;                     // Command or address byte
	} nfh_step_t;

	typedef struct packed {
		logic       ce_n;                    // Chip select, active low
		logic       cle;                     // Command latch enable
		logic       ale;                     // Address latch enable
		logic       we_n;                    // Write strobe, active low
		logic       re_n;                    // read_strobe_n
		logic [7:0] dq;                      // Data bus, outgoing
		logic       dq_oe;                   // High while host drives dq
	} nfh_pins_t;

endpackage : nfh_pkg
`default_nettype wire

// ==== nfh_cycle.sv ====
`timescale 1ns/1ps
`default_nettype none
// One bus cycle on the flash pins: command, address or data read
module nfh_cycle (
	input  wire logic              core_clk_i,
	input  wire logic              arst_n_i,
	input  wire logic              start_i,    // Begin one cycle
	input  wire nfh_pkg::nfh_bkind_t kind_i,   // Cycle type
	input  wire logic [7:0]        byte_i,     // Byte to write
	input  wire logic              ce_hold_i,  // Keep chip selected
	input  wire logic [7:0]        dq_i,       // Raw data pins
	output nfh_pkg::nfh_pins_t     pins_o,     // Registered pins
	output logic                   done_o,     // Cycle finished pulse
	output logic [7:0]             rdata_o     // Byte caught on read
);
	import nfh_pkg::*;

	// ==========================================================
	// State
	// ==========================================================
	typedef enum logic [1:0] {CY_IDLE, CY_LOW, CY_HIGH} nfh_cy_t;
	nfh_cy_t    state_reg, state_next;       // Strobe phase
	logic [3:0] cnt_reg, cnt_next;           // Phase length counter
	nfh_pins_t  pins_reg, pins_next;         // Pin image
	logic       done_reg, done_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [7:0] dq_s1, dq_s2;                // Two-stage dq synchroniser
	logic       is_read;

	// ==========================================================
	// Input synchroniser
	// ==========================================================
	// dq comes from the device, not from this clock
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			dq_s1 <= 8'h00;
			dq_s2 <= 8'h00;
		end else begin
			dq_s1 <= dq_i;
			dq_s2 <= dq_s1;
		end
	end

	// ==========================================================
	// Strobe sequencing
	// ==========================================================
	assign is_read = (kind_i == BK_READ);

	// Next phase, counter and pin image
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		pins_next  = pins_reg;
		done_next  = 1'b0;
		rdata_next = rdata_reg;
		unique case (state_reg)
			CY_IDLE: begin
				pins_next.ce_n = ~ce_hold_i;
				if (start_i) begin
					// Latch enables and strobe move together
					pins_next.ce_n  = 1'b0;
					pins_next.cle   = (kind_i == BK_CMD);
					pins_next.ale   = (kind_i == BK_ADDR);
					pins_next.we_n  = is_read;
					pins_next.re_n  = ~is_read;
					pins_next.dq    = byte_i;
					pins_next.dq_oe = ~is_read;
					cnt_next = is_read ? 4'(RDL_CYC - 1) : 4'(WP_CYC - 1);
					state_next = CY_LOW;
				end
			end
			CY_LOW: begin
				if (cnt_reg == 4'h0) begin
					// Read strobe low long enough for two sync stages
					if (pins_reg.re_n == 1'b0) begin
						rdata_next = dq_s2;
					end
					pins_next.we_n = 1'b1;
					pins_next.re_n = 1'b1;
					cnt_next   = 4'(WH_CYC - 1);
					state_next = CY_HIGH;
				end else begin
					cnt_next = cnt_reg - 4'h1;
				end
			end
			CY_HIGH: begin
				if (cnt_reg == 4'h0) begin
					// Data and latches held through the high phase
					pins_next.cle   = 1'b0;
					pins_next.ale   = 1'b0;
					pins_next.dq_oe = 1'b0;
					done_next  = 1'b1;
					state_next = CY_IDLE;
				end else begin
					cnt_next = cnt_reg - 4'h1;
				end
			end
		endcase
	end

	// Register the phase state
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg <= CY_IDLE;
			cnt_reg   <= 4'h0;
			pins_reg  <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
				re_n: 1'b1, dq: 8'h00, dq_oe: 1'b0};
			done_reg  <= 1'b0;
			rdata_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			pins_reg  <= pins_next;
			done_reg  <= done_next;
			rdata_reg <= rdata_next;
		end
	end

	assign pins_o  = pins_reg;
	assign done_o  = done_reg;
	assign rdata_o = rdata_reg;

endmodule : nfh_cycle
`default_nettype wire

// ==== nfh_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module nfh_ctrl (
	input  wire logic               core_clk_i,
	input  wire logic               arst_n_i,
	input  wire logic [7:0]         reg_addr_i,  // Register byte address
	input  wire logic [31:0]        reg_wdata_i, // Write data
	input  wire logic               reg_wr_i,    // Write strobe
	input  wire logic               reg_rd_i,    // Read strobe
	output logic [31:0]             reg_rdata_o, // Read data, next cycle
	input  wire logic [7:0]         dq_i,        // Flash data pins in
	input  wire logic               rb_n_i,      // Ready/busy pin
	output nfh_pkg::nfh_pins_t      pins_o,      // Flash bus pins
	output logic                    wp_n_o       // Write-protect pin
);
	import nfh_pkg::*;

	// ==========================================================
	// State and registers
	// ==========================================================
	typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_BUSY, ST_GAP} nfh_st_t;
	nfh_st_t     st_reg, st_next;            // Sequencer state
	nfh_op_t     op_reg, op_next;            // Order being run
	logic [3:0]  step_reg, step_next;        // Position in the order
	logic [3:0]  gap_reg, gap_next;          // Delay counter
	logic [6:3]  cfg_reg, cfg_next;          // poll, wp_off, multi, otp
	logic [23:0] row_reg, row_next;          // Page, block, die_unit
	logic [15:0] col_reg, col_next;          // Cache column
	logic [7:0]  ds_reg, ds_next;            // Latest die_status, masked
	logic [7:0]  data_reg, data_next;        // Latest data byte
	logic        smode_reg, smode_next;      // Device shows status
	logic        dsel_reg, dsel_next;        // One die picked by 78h
	logic        ref_reg, ref_next;          // Order refused, sticky
	logic [31:0] rdata_reg, rdata_next;
	logic        rb_s1, rb_s2;               // Ready/busy synchroniser
	logic        eng_start;
	nfh_bkind_t  eng_kind;
	logic        eng_done;
	logic [7:0]  eng_rdata;
	nfh_step_t   cur;                        // Current step of the order
	nfh_op_t     wr_op;                      // Op field of a CTRL write
	logic        refuse;                     // Host-side guard trips

	// ==========================================================
	// Order tables
	// ==========================================================
	// Each order is a short list of bus steps; IT_END closes it
	function automatic nfh_step_t step_of(input nfh_op_t op,
		input logic [3:0] s, input logic [23:0] row,
		input logic [15:0] col);
		nfh_step_t r;
		r = '{kind: IT_END, val: 8'h00};
		unique case (op)
			OP_STATUS: begin
				if (s == 4'h0) r = '{kind: IT_CMD, val: CMD_STATUS};
				if (s == 4'h1) r = '{kind: IT_GAP, val: 8'h00};
				if (s == 4'h2) r = '{kind: IT_READ, val: 8'h00};
			end
			OP_STATUS_ENH: begin
				// Row cycles name the die and plane to report
				if (s == 4'h0) r = '{kind: IT_CMD, val: CMD_STATUS_ENH};
				if (s == 4'h1) r = '{kind: IT_ADDR, val: row[7:0]};
				if (s == 4'h2) r = '{kind: IT_ADDR, val: row[15:8]};
				if (s == 4'h3) r = '{kind: IT_ADDR, val: row[23:16]};
				if (s == 4'h4) r = '{kind: IT_GAP, val: 8'h00};
				if (s == 4'h5) r = '{kind: IT_READ, val: 8'h00};
			end
			OP_READ_MODE: begin
				if (s == 4'h0) r = '{kind: IT_CMD, val: CMD_READ_MODE};
			end
			OP_RAND_READ: begin
				// Full 16-bit column reaches any byte of the cache
				if (s == 4'h0) r = '{kind: IT_CMD, val: CMD_RAND_READ};
				if (s == 4'h1) r = '{kind: IT_ADDR, val: col[7:0]};
				if (s == 4'h2) r = '{kind: IT_ADDR, val: col[15:8]};
				if (s == 4'h3) r = '{kind: IT_CMD, val: CMD_RAND_CONF};
				if (s == 4'h4) r = '{kind: IT_GAP, val: 8'h00};
			end
			OP_DATA_READ: begin
				// Steps 0-1 run only when status output is on
				if (s == 4'h0) r = '{kind: IT_CMD, val: CMD_READ_MODE};
				if (s == 4'h1) r = '{kind: IT_GAP, val: 8'h00};
				if (s == 4'h2) r = '{kind: IT_READ, val: 8'h00};
			end
			default: r = '{kind: IT_END, val: 8'h00};
		endcase
		return r;
	endfunction : step_of

	assign cur   = step_of(op_reg, step_reg, row_reg, col_reg);
	assign wr_op = nfh_op_t'(reg_wdata_i[CF_OP_MSB:CF_OP_LSB]);

	// Guards against bus contention and forbidden moments
	// Judged on the incoming config bits, not on cfg_next, which would
	// close a loop through the next-value process
	assign refuse = (reg_wdata_i[CF_MULTI] && wr_op == OP_STATUS)
		|| (reg_wdata_i[CF_OTP] && wr_op == OP_STATUS_ENH)
		|| (reg_wdata_i[CF_MULTI] && wr_op == OP_RAND_READ
		&& !dsel_reg);

	assign eng_start = (st_reg == ST_ISSUE)
		&& (cur.kind == IT_CMD || cur.kind == IT_ADDR
		|| cur.kind == IT_READ);
	assign eng_kind = (cur.kind == IT_CMD) ? BK_CMD
		: (cur.kind == IT_ADDR) ? BK_ADDR : BK_READ;

	// ==========================================================
	// Pin cycle engine
	// ==========================================================
	nfh_cycle u_cycle (
		.core_clk_i (core_clk_i),
		.arst_n_i   (arst_n_i),
		.start_i    (eng_start),
		.kind_i     (eng_kind),
		.byte_i     (cur.val),
		.ce_hold_i  (st_reg != ST_IDLE),
		.dq_i       (dq_i),
		.pins_o     (pins_o),
		.done_o     (eng_done),
		.rdata_o    (eng_rdata)
	);

	// ==========================================================
	// Sequencer and register file, next values
	// ==========================================================
	always_comb begin
		st_next    = st_reg;
		op_next    = op_reg;
		step_next  = step_reg;
		gap_next   = gap_reg;
		cfg_next   = cfg_reg;
		row_next   = row_reg;
		col_next   = col_reg;
		ds_next    = ds_reg;
		data_next  = data_reg;
		smode_next = smode_reg;
		dsel_next  = dsel_reg;
		ref_next   = ref_reg;
		rdata_next = 32'h0000_0000;
		// Software writes; CTRL also launches an order
		if (reg_wr_i && reg_addr_i == OFF_ROW) row_next = reg_wdata_i[23:0];
		if (reg_wr_i && reg_addr_i == OFF_COL) col_next = reg_wdata_i[15:0];
		if (reg_wr_i && reg_addr_i == OFF_CTRL) begin
			cfg_next = reg_wdata_i[CF_OTP:CF_POLL];
			ref_next = 1'b0;
			if (st_reg == ST_IDLE && wr_op != OP_NOP) begin
				if (refuse) begin
					ref_next = 1'b1;    // Set wins over the clear
				end else begin
					op_next   = wr_op;
					// Data read skips read-mode unless status is on
					step_next = (wr_op == OP_DATA_READ && !smode_reg)
						? 4'h2 : 4'h0;
					st_next   = ST_ISSUE;
				end
			end
		end
		unique case (st_reg)
			ST_IDLE: ;
			ST_ISSUE: begin
				if (cur.kind == IT_END) begin
					st_next = ST_IDLE;
				end else if (cur.kind == IT_GAP) begin
					gap_next = 4'(WHR_CYC - 1);
					st_next  = ST_GAP;
				end else begin
					st_next = ST_BUSY;
				end
				// Track what the device will answer with
				if (cur.kind == IT_CMD) begin
					if (cur.val == CMD_STATUS
						|| cur.val == CMD_STATUS_ENH) smode_next = 1'b1;
					if (cur.val == CMD_READ_MODE
						|| cur.val == CMD_RAND_CONF) smode_next = 1'b0;
					if (cur.val == CMD_STATUS_ENH) dsel_next = 1'b1;
				end
			end
			ST_BUSY: begin
				if (eng_done) begin
					st_next   = ST_ISSUE;
					step_next = step_reg + 4'h1;
					if (cur.kind == IT_READ && op_reg == OP_DATA_READ) begin
						data_next = eng_rdata;
					end else if (cur.kind == IT_READ) begin
						ds_next = eng_rdata & STATUS_MASK;
						// Polling re-reads the live status byte
						if (cfg_reg[CF_POLL] && !eng_rdata[SB_RDY]) begin
							step_next = step_reg;
						end
					end
				end
			end
			ST_GAP: begin
				if (gap_reg == 4'h0) begin
					st_next   = ST_ISSUE;
					step_next = step_reg + 4'h1;
				end else begin
					gap_next = gap_reg - 4'h1;
				end
			end
		endcase
		// Register reads answer in the following cycle only
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				OFF_CTRL: rdata_next[CF_OTP:CF_POLL] = cfg_reg;
				OFF_ROW:  rdata_next[23:0] = row_reg;
				OFF_COL:  rdata_next[15:0] = col_reg;
				OFF_STAT: begin
					rdata_next[ST_BUSY_B] = (st_reg != ST_IDLE);
					rdata_next[ST_REF_B]  = ref_reg;
					rdata_next[ST_RB_B]   = rb_s2;
					rdata_next[ST_SMODE]  = smode_reg;
					rdata_next[ST_DSEL]   = dsel_reg;
					rdata_next[ST_DS_LSB +: 8] = ds_reg;
				end
				OFF_DATA: rdata_next[7:0] = data_reg;
				default:  rdata_next = 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// Registers
	// ==========================================================
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_reg    <= ST_IDLE;
			op_reg    <= OP_NOP;
			step_reg  <= 4'h0;
			gap_reg   <= 4'h0;
			cfg_reg   <= 4'h0;
			row_reg   <= 24'h00_0000;
			col_reg   <= 16'h0000;
			ds_reg    <= 8'h00;
			data_reg  <= 8'h00;
			smode_reg <= 1'b0;
			dsel_reg  <= 1'b0;
			ref_reg   <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			wp_n_o    <= 1'b0;
			rb_s1     <= 1'b0;
			rb_s2     <= 1'b0;
		end else begin
			st_reg    <= st_next;
			op_reg    <= op_next;
			step_reg  <= step_next;
			gap_reg   <= gap_next;
			cfg_reg   <= cfg_next;
			row_reg   <= row_next;
			col_reg   <= col_next;
			ds_reg    <= ds_next;
			data_reg  <= data_next;
			smode_reg <= smode_next;
			dsel_reg  <= dsel_next;
			ref_reg   <= ref_next;
			rdata_reg <= rdata_next;
			wp_n_o    <= cfg_next[CF_WP_OFF];
			rb_s1     <= rb_n_i;
			rb_s2     <= rb_s1;
		end
	end

	assign reg_rdata_o = rdata_reg;

	// ==========================================================
	// Checks
	// ==========================================================
	logic [7:0] since_reg;                   // Cycles since last cmd/addr
	logic [7:0] last_cmd_reg;                // Last command byte sent
	logic [1:0] addr_cnt_reg;                // Address cycles after it
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			since_reg    <= 8'h00;
			last_cmd_reg <= 8'hff;
			addr_cnt_reg <= 2'h0;
		end else begin
			if (eng_start && eng_kind != BK_READ) since_reg <= 8'h00;
			else if (since_reg != 8'hff) since_reg <= since_reg + 8'h01;
			if (eng_start && eng_kind == BK_CMD) begin
				last_cmd_reg <= cur.val;
				addr_cnt_reg <= 2'h0;
			end else if (eng_start && eng_kind == BK_ADDR) begin
				addr_cnt_reg <= addr_cnt_reg + 2'h1;
			end
		end
	end

	property p_no_plain_multi;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		(eng_start && eng_kind == BK_CMD && cfg_reg[CF_MULTI])
			|-> cur.val != CMD_STATUS;
	endproperty
	a_no_plain_multi: assert property (p_no_plain_multi)
		else $error("plain status sent on a multi-die target");
	property p_no_enh_otp;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		(eng_start && eng_kind == BK_CMD && cfg_reg[CF_OTP])
			|-> cur.val != CMD_STATUS_ENH;
	endproperty
	a_no_enh_otp: assert property (p_no_enh_otp)
		else $error("enhanced status sent in OTP mode");
	property p_rand_sel;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		(eng_start && eng_kind == BK_CMD && cur.val == CMD_RAND_READ
			&& cfg_reg[CF_MULTI]) |-> dsel_reg;
	endproperty
	a_rand_sel: assert property (p_rand_sel)
		else $error("random read without a selected die");
	property p_masked;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		$changed(ds_reg) |-> !ds_reg[SB_DC];
	endproperty
	a_masked: assert property (p_masked)
		else $error("status bit 2 kept");
	property p_mode_first;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		(eng_start && eng_kind == BK_READ && op_reg == OP_DATA_READ)
			|-> !smode_reg;
	endproperty
	a_mode_first: assert property (p_mode_first)
		else $error("data read while status output is on");
	property p_whr;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		(eng_start && eng_kind == BK_READ) |-> since_reg >= 8'(WHR_CYC);
	endproperty
	a_whr: assert property (p_whr)
		else $error("data read before write_to_read_delay");
	property p_rand_seq;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		(eng_start && eng_kind == BK_CMD && cur.val == CMD_RAND_CONF)
			|-> last_cmd_reg == CMD_RAND_READ && addr_cnt_reg == 2'h2;
	endproperty
	a_rand_seq: assert property (p_rand_seq)
		else $error("E0h without 05h and two column cycles");
	property p_enh_rows;
		@(posedge core_clk_i) disable iff (!arst_n_i)
		(eng_start && eng_kind == BK_READ && op_reg == OP_STATUS_ENH)
			|-> last_cmd_reg == CMD_STATUS_ENH && addr_cnt_reg == 2'h3;
	endproperty
	a_enh_rows: assert property (p_enh_rows)
		else $error("enhanced status read without three row cycles");

endmodule : nfh_ctrl
`default_nettype wire

// ==== nfh_die.sv ====
`timescale 1ns/1ps
`default_nettype none
// ====
// Behavioural flash die, one plane, seen from the host pins
module nfh_die (
	input  wire nfh_pkg::nfh_pins_t pins_i, // Host pins
	input  wire logic [7:0]         sts_i,  // Live status byte
	output logic [7:0]              dq_o    // Data pins
);
	import nfh_pkg::*;
	logic        smode = 1'b0;     // Status output on
	logic [7:0]  cmd   = 8'h00;    // Last command byte
	logic        hi    = 1'b0;     // Next column byte is the high one
	logic [15:0] col   = 16'h0000; // Cache column
	logic [7:0]  val;              // Byte offered to the bus
	// Commands and addresses latch on the write strobe rise
	always @(posedge pins_i.we_n) begin
		if (!pins_i.ce_n && pins_i.cle) begin
			cmd = pins_i.dq;
			hi = 1'b0;
			if (cmd == CMD_STATUS || cmd == CMD_STATUS_ENH)
				smode = 1'b1;
			if (cmd == CMD_READ_MODE || cmd == CMD_RAND_CONF)
				smode = 1'b0;
		end else if (!pins_i.ce_n && pins_i.ale && cmd == CMD_RAND_READ) begin
			if (hi)
				col[15:8] = pins_i.dq;
			else
				col[7:0] = pins_i.dq;
			hi = 1'b1;
		end
	end
	// Each data output moves the column on
	always @(posedge pins_i.re_n)
		if (!pins_i.ce_n && !smode)
			col = col + 16'h0001;
	// Status is live, no strobe edge needed; a released bus shows the
	// inverse so a stale byte can never pass for a fresh one
	assign val  = smode ? sts_i : (col[7:0] ^ 8'h3c);
	assign dq_o = (!pins_i.ce_n && !pins_i.re_n) ? val : ~val;
endmodule : nfh_die
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
	import nfh_pkg::*;
	logic        clk   = 1'b0;  // 125 MHz core clock
	logic        rst_n = 1'b0;  // Reset, active low
	logic [7:0]  addr  = 8'h00; // Register address
	logic [31:0] wdata = 32'h0; // Register write data
	logic        wr    = 1'b0;  // Write strobe
	logic        rd    = 1'b0;  // Read strobe
	logic [7:0]  sts   = 8'he4; // Die status, bit 2 set on purpose
	logic [31:0] rdata;         // Register read data
	logic [7:0]  dq;            // Die data pins
	logic        wp_n;          // Write-protect pin
	nfh_pins_t   pins;          // Flash bus
	int          error_cnt = 0;
	int          samples_checked = 0;
	int          i;
	logic [31:0] v;
	nfh_ctrl uut (.core_clk_i(clk), .arst_n_i(rst_n), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdata), .dq_i(dq), .rb_n_i(sts[SB_RDY]),
		.pins_o(pins), .wp_n_o(wp_n));
	nfh_die die (.pins_i(pins), .sts_i(sts), .dq_o(dq));
	task automatic report_and_stop();
		$display("Checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rchk(input logic [7:0] a, input logic [31:0] m, e);
		rd_reg(a, v);
		chk(v & m, e);
	endtask : rchk
	// Bounded wait for the sequencer to go idle
	task automatic wt();
		repeat (3) @(posedge clk);
		for (int n = 0; n < 600; n++) begin
			rd_reg(OFF_STAT, v);
			if (v[ST_BUSY_B] === 1'b0)
				return;
		end
		error_cnt++;
		$display("Error %0t: sequencer hung", $time);
		report_and_stop();
	endtask : wt
	task automatic run(input logic [31:0] d);
		wr_reg(OFF_CTRL, d);
		wt();
	endtask : run
	initial forever #4 clk = ~clk;
	// ====
	// Main sequence
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		chk({31'h0, wp_n}, 32'h0);
		run(32'h24);
		rchk(OFF_STAT, 32'h3, 32'h2);
		run(32'h21);
		rchk(OFF_STAT, 32'h3, 32'h2);
		run(32'h52);
		rchk(OFF_STAT, 32'h3, 32'h2);
		run(32'h11);
		chk({31'h0, wp_n}, 32'h1);
		rchk(OFF_STAT, 32'hff0a, 32'he008);
		// Four error-level code and fail bit combinations, sts = 3bh times 1 to 4
		for (i = 1; i < 5; i++) begin
			sts <= 8'(8'h3b * i);
			run(32'h12);
			rchk(OFF_STAT, 32'hff1a, {16'h0, sts & STATUS_MASK, 8'h18});
		end
		run(32'h13);
		rchk(OFF_STAT, 32'h8, 32'h0);
		wr_reg(OFF_COL, 32'h0123);
		run(32'h14);
		rchk(OFF_STAT, 32'h8, 32'h0);
		run(32'h15);
		rchk(OFF_DATA, 32'hff, 32'h1f);
		run(32'h15);
		rchk(OFF_DATA, 32'hff, 32'h18);
		wr_reg(OFF_COL, 32'h01fe);
		run(32'h34);
		rchk(OFF_STAT, 32'h3, 32'h0);
		run(32'h35);
		rchk(OFF_DATA, 32'hff, 32'hc2);
		// Poll while busy, ready arrives mid-read
		sts <= 8'h24;
		wr_reg(OFF_CTRL, 32'h19);
		repeat (200) @(posedge clk);
		rchk(OFF_STAT, 32'h5, 32'h1);
		sts <= 8'he0;
		wt();
		rchk(OFF_STAT, 32'hff0c, 32'he00c);
		// Data read while status output is on must send read-mode first
		run(32'h15);
		rchk(OFF_DATA, 32'hff, 32'hc3);
		rchk(OFF_STAT, 32'h8, 32'h0);
		rchk(8'h14, 32'hffffffff, 32'h0);
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
